//--- hw/loop_detector_config_output_ctrl.sv
// switch decode, tuning control, direction logic and indicators of the loop detector
`timescale 1ns/100ps
module loop_detector_config_output_ctrl #(
    parameter int unsigned MS_CYC = loop_det_pkg::MS_CYCLES,
    parameter int unsigned LIM_UNIT = loop_det_pkg::LIM_UNIT_MS
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // front panel switches and internal jumper
    input wire logic freq_select_hi_bit,
    input wire logic freq_select_lo_bit,
    input wire logic ch1_sens_a,
    input wire logic ch1_sens_b,
    input wire logic ch2_sens_a,
    input wire logic ch2_sens_b,
    input wire logic boost_enable_switch,
    input wire logic presence_time_switch,
    input wire logic ch1_pulse_select,
    input wire logic ch2_pulse_select,
    input wire logic [1:0] direction_logic_jumper,
    input wire logic reset_switch,
    // loop measurement front end
    input wire logic [1:0] loop_detect,
    input wire logic [1:0] loop_fault,
    input wire logic [1:0][3:0] delta_mag,
    input wire logic tune_done,
    output logic tune_req,
    output logic osc_mux_sel,
    output logic [1:0] osc_freq_sel,
    output logic [1:0][1:0] sens_level,
    output logic [1:0] drift_track,
    // power-fail retention
    input wire logic pf_option_fitted,
    input wire logic pf_outage_short,
    input wire logic [1:0] pf_saved_det,
    output logic [1:0] pf_store_det,
    // relays and indicators
    output logic [1:0] relay_close,
    output logic [1:0] chan_led,
    output logic power_led
);
    import loop_det_pkg::*;

    localparam logic [16:0] MS_LAST = 17'(MS_CYC - 1);
    localparam logic [9:0] ALT_LAST = 10'(ALT_HALF_MS - 1);
    localparam logic [9:0] FLT_LAST = 10'(FAULT_HALF_MS - 1);

    // ****
    // state
    // ****
    typedef struct packed {
        logic [1:0] freq;
        logic [1:0][1:0] sens;
        logic boost;
        logic perm;
        logic [1:0] pulse;
        dir_mode_t dir;
    } cfg_t;

    typedef struct packed {
        tune_state_t st;
        cfg_t cfg;
        logic [16:0] ms_cnt;
        logic ms_tick;
        logic [9:0] alt_cnt;
        logic [9:0] flt_cnt;
        logic alt;
        logic fflash;
        logic [7:0] settle;
        logic [1:0] restore;
        logic rsw_d;
        logic retune;
        logic diag_en;
        logic diag_bit;
        logic [1:0] loop_q;
        logic [1:0][31:0] lim_cnt;
        logic [1:0][31:0] lim_max;
        logic [1:0] lim_exp;
        logic [1:0] det;
        logic [1:0] det_prev;
        logic [1:0] fault_lat;
        logic [1:0] origin;
        logic tune_req;
        logic mux_sel;
        logic [1:0][1:0] sens_out;
        logic [1:0] track;
        logic [1:0] led;
        logic pwr_led;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ctrl_st_t;

    ctrl_st_t s_r;
    ctrl_st_t s_nxt;
    cfg_t cfg_now;
    logic [1:0] lvl;
    logic [1:0] trg;
    logic pmode;
    chan_if ci[2] ();

    // ****
    // switch decode
    // ****
    function automatic dir_mode_t jumper_mode(input logic [1:0] j);
        if (j == 2'b01) begin
            return DIR_PRES;
        end else if (j == 2'b10) begin
            return DIR_PULSE;
        end else begin
            return DIR_NONE;
        end
    endfunction

    always_comb begin
        cfg_now.freq = {freq_select_hi_bit, freq_select_lo_bit};
        cfg_now.sens[0] = {ch1_sens_b, ch1_sens_a};
        cfg_now.sens[1] = {ch2_sens_b, ch2_sens_a};
        cfg_now.boost = boost_enable_switch;
        cfg_now.perm = presence_time_switch;
        cfg_now.pulse = {ch2_pulse_select, ch1_pulse_select};
        cfg_now.dir = jumper_mode(direction_logic_jumper);
    end

    // ****
    // next state
    // ****
    always_comb begin
        logic start;
        logic tuning;
        logic wr;
        start = 1'b0;
        tuning = 1'b0;
        wr = 1'b0;
        s_nxt = s_r;
        s_nxt.ms_tick = 1'b0;
        s_nxt.tune_req = 1'b0;
        s_nxt.retune = 1'b0;
        if (s_r.ms_cnt == MS_LAST) begin
            s_nxt.ms_cnt = '0;
            s_nxt.ms_tick = 1'b1;
        end else begin
            s_nxt.ms_cnt = s_r.ms_cnt + 17'h00001;
        end
        if (s_r.ms_tick) begin
            s_nxt.mux_sel = ~s_r.mux_sel;
            if (s_r.alt_cnt == ALT_LAST) begin
                s_nxt.alt_cnt = '0;
                s_nxt.alt = ~s_r.alt;
            end else begin
                s_nxt.alt_cnt = s_r.alt_cnt + 10'h001;
            end
            if (s_r.flt_cnt == FLT_LAST) begin
                s_nxt.flt_cnt = '0;
                s_nxt.fflash = ~s_r.fflash;
            end else begin
                s_nxt.flt_cnt = s_r.flt_cnt + 10'h001;
            end
            if (s_r.settle != 8'h00) begin
                s_nxt.settle = s_r.settle - 8'h01;
            end else begin
                s_nxt.restore = 2'b00;
            end
        end
        // apb: answer prepared in setup, completed in access
        s_nxt.pready = psel & ~penable;
        s_nxt.pslverr = 1'b0;
        if (psel && !penable) begin
            s_nxt.prdata = '0;
            if (paddr == CTRL_OFF) begin
                s_nxt.prdata[2:0] = {s_r.diag_bit, s_r.diag_en, 1'b0};
            end else if (paddr == STATUS_OFF) begin
                s_nxt.prdata[8:0] = {ci[1].relay, ci[0].relay, s_r.lim_exp, s_r.fault_lat,
                                     s_r.det, (s_r.st != ST_RUN)};
            end else if (paddr == CONFIG_OFF) begin
                s_nxt.prdata[12:0] = {s_r.cfg[11:2], 1'b0, s_r.cfg[1:0]};
            end else begin
                s_nxt.pslverr = 1'b1;
            end
        end else if (!psel || s_r.pready) begin
            s_nxt.prdata = '0;
        end
        wr = psel & penable & s_r.pready & pwrite;
        if (wr && paddr == CTRL_OFF) begin
            s_nxt.retune = pwdata[CTRL_RETUNE_BIT];
            s_nxt.diag_en = pwdata[CTRL_DIAG_EN_BIT];
            s_nxt.diag_bit = pwdata[CTRL_DIAG_BIT];
        end
        s_nxt.rsw_d = reset_switch;
        start = (reset_switch & ~s_r.rsw_d) | s_r.retune;
        case (s_r.st)
            ST_POWER: begin
                s_nxt.cfg = cfg_now;
                if (pf_option_fitted && pf_outage_short) begin
                    s_nxt.restore = pf_saved_det;
                    s_nxt.settle = 8'(PF_SETTLE_MS);
                    s_nxt.st = ST_RUN;
                end else begin
                    s_nxt.tune_req = 1'b1;
                    s_nxt.st = ST_TUNE;
                end
            end
            ST_TUNE: begin
                if (tune_done) begin
                    s_nxt.st = ST_RUN;
                end
            end
            default: begin
            end
        endcase
        if (start) begin
            s_nxt.cfg = cfg_now;
            s_nxt.tune_req = 1'b1;
            s_nxt.st = ST_TUNE;
            s_nxt.fault_lat = 2'b00;
            s_nxt.restore = 2'b00;
        end
        tuning = (s_r.st != ST_RUN);
        s_nxt.loop_q = loop_detect;
        for (int i = 0; i < 2; i++) begin
            if (!loop_detect[i] || tuning) begin
                s_nxt.lim_cnt[i] = '0;
                s_nxt.lim_exp[i] = 1'b0;
            end else if (!s_r.loop_q[i]) begin
                s_nxt.lim_cnt[i] = '0;
                s_nxt.lim_max[i] = LIM_UNIT * (32'(delta_mag[i]) + 32'd1);
            end else if (!s_r.cfg.perm && s_r.ms_tick && !s_r.lim_exp[i]) begin
                s_nxt.lim_cnt[i] = s_r.lim_cnt[i] + 32'd1;
                s_nxt.lim_exp[i] = (s_nxt.lim_cnt[i] >= s_r.lim_max[i]);
            end
            s_nxt.det[i] = (loop_detect[i] & ~s_r.lim_exp[i] & ~tuning) | s_r.restore[i];
            // latched fault, set wins over clear
            if (loop_fault[i]) begin
                s_nxt.fault_lat[i] = 1'b1;
            end
            s_nxt.sens_out[i] = (s_r.cfg.boost && s_r.det[i]) ? SENS_MAX : s_r.cfg.sens[i];
            s_nxt.track[i] = s_r.cfg.perm & s_r.det[i];
            if (tuning) begin
                if (s_r.cfg.dir != DIR_NONE) begin
                    s_nxt.led[i] = (i == 0) ? s_r.alt : ~s_r.alt;
                end else begin
                    s_nxt.led[i] = 1'b1;
                end
            end else if (loop_fault[i] || s_r.fault_lat[i]) begin
                s_nxt.led[i] = s_r.fflash;
            end else begin
                s_nxt.led[i] = s_r.det[i];
            end
        end
        s_nxt.det_prev = s_r.det;
        // direction origin: which loop the vehicle entered first
        if (!s_r.det[0] && !s_r.det[1]) begin
            s_nxt.origin = 2'b00;
        end else if (s_r.origin == 2'b00) begin
            if (s_r.det[0] && !s_r.det[1]) begin
                s_nxt.origin = 2'b01;
            end else if (s_r.det[1] && !s_r.det[0]) begin
                s_nxt.origin = 2'b10;
            end
        end
        s_nxt.pwr_led = s_r.diag_en ? s_r.diag_bit : 1'b1;
    end

    // ****
    // relay requests
    // ****
    always_comb begin
        lvl = 2'b00;
        trg = 2'b00;
        pmode = 1'b0;
        case (s_r.cfg.dir)
            DIR_PRES: begin
                // origin relay while over other loop
                lvl[0] = s_r.origin[0] & s_r.det[1];
                lvl[1] = s_r.origin[1] & s_r.det[0];
            end
            DIR_PULSE: begin
                pmode = 1'b1;
                // pulse as vehicle leaves origin loop
                trg[0] = s_r.origin[0] & s_r.det_prev[0] & ~s_r.det[0] & s_r.det[1];
                trg[1] = s_r.origin[1] & s_r.det_prev[1] & ~s_r.det[1] & s_r.det[0];
            end
            default: begin
                lvl = s_r.det | (loop_fault & ~s_r.cfg.pulse);
                trg = s_r.det & ~s_r.det_prev;
            end
        endcase
    end

    generate
        for (genvar g = 0; g < 2; g++) begin : g_chan
            assign ci[g].ms_tick = s_r.ms_tick;
            assign ci[g].pulse_mode = (s_r.cfg.dir == DIR_NONE) ? s_r.cfg.pulse[g] : pmode;
            assign ci[g].level = lvl[g];
            assign ci[g].trig = trg[g];
            relay_shaper u_shaper (
                .pclk(pclk),
                .presetn(presetn),
                .ch(ci[g].shaper)
            );
        end
    endgenerate

    // ****
    // registers and outputs
    // ****
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.st <= ST_POWER;
            s_r.cfg.dir <= DIR_NONE;
            s_r.pwr_led <= 1'b1;
            s_r.rsw_d <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign tune_req = s_r.tune_req;
    assign osc_mux_sel = s_r.mux_sel;
    assign osc_freq_sel = s_r.cfg.freq;
    assign sens_level = s_r.sens_out;
    assign drift_track = s_r.track;
    assign pf_store_det = s_r.det;
    assign relay_close = {ci[1].relay, ci[0].relay};
    assign chan_led = s_r.led;
    assign power_led = s_r.pwr_led;
endmodule // loop_detector_config_output_ctrl

//--- hw/loop_det_pkg.sv
// shared constants and types of the loop detector
//
// Contract
// - frequency switches pick one of four frequencies
// - loops share one multiplexed oscillator
// - switch pair picks channel sensitivity
// - boost switch enables boost
// - boost holds maximum sensitivity while detected
// - switch picks limited or permanent presence
// - permanent presence tracks drift in detect
// - limited presence times out by change size
// - switches pick presence or pulse relay
// - power-up starts tuning
// - reset press restarts tuning
// - jumper picks direction logic mode
// - default presence relays, no direction logic
// - power-fail option restores detect state
// - channel LED lit while tuning
// - direction logic LEDs alternate while tuning
// - loop fault flashes channel LED
// - healed fault latched on LED until reset
// - channel LED lit while detected
// - power LED lit, also diagnostic link
// - relays follow channel mode
// - presence holds output while present
// - pulse mode gives 150 ms pulse on entry
// - presence direction closes origin relay
// - pulse direction pulses origin relay
package loop_det_pkg;
    // ****
    // timing
    // ****
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned MS_NS = 1000000;
    localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int unsigned PULSE_MS = 150;
    localparam int unsigned ALT_HALF_MS = 500;
    localparam int unsigned FAULT_HALF_MS = 125;
    localparam int unsigned PF_SETTLE_MS = 100;
    localparam int unsigned LIM_UNIT_MS = 60000;
    // ****
    // register map
    // ****
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STATUS_OFF = 12'h004;
    localparam logic [11:0] CONFIG_OFF = 12'h008;
    localparam int CTRL_RETUNE_BIT = 0;
    localparam int CTRL_DIAG_EN_BIT = 1;
    localparam int CTRL_DIAG_BIT = 2;
    // ****
    // encodings
    // ****
    localparam logic [1:0] SENS_MAX = 2'h0;
    typedef enum logic [1:0] {DIR_NONE, DIR_PRES, DIR_PULSE} dir_mode_t;
    typedef enum logic [1:0] {ST_POWER, ST_TUNE, ST_RUN} tune_state_t;
endpackage

//--- hw/chan_if.sv
// per-channel request bundle between the controller and the relay shaper
`timescale 1ns/100ps
interface chan_if;
    logic ms_tick;
    logic pulse_mode;
    logic level;
    logic trig;
    logic relay;
    modport ctrl (output ms_tick, pulse_mode, level, trig, input relay);
    modport shaper (input ms_tick, pulse_mode, level, trig, output relay);
endinterface

//--- hw/relay_shaper.sv
// relay drive for one channel: presence level or timed pulse
`timescale 1ns/100ps
module relay_shaper (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // channel requests
    chan_if.shaper ch
);
    import loop_det_pkg::*;

    typedef struct packed {
        logic [7:0] cnt;
        logic relay;
    } shaper_st_t;

    shaper_st_t s_r;
    shaper_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (ch.pulse_mode) begin
            if (ch.trig) begin
                s_nxt.cnt = 8'(PULSE_MS + 1);
            end else if (ch.ms_tick && s_r.cnt != 8'h00) begin
                s_nxt.cnt = s_r.cnt - 8'h01;
            end
            s_nxt.relay = (s_nxt.cnt != 8'h00);
        end else begin
            s_nxt.cnt = 8'h00;
            s_nxt.relay = ch.level;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ch.relay = s_r.relay;
endmodule // relay_shaper

//--- tb/loop_det_checker.sv
// assertions on the loop detector control block ports
`timescale 1ns/100ps
module loop_det_checker #(
    parameter int unsigned MS_CYC = 10
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // switches and front end
    input wire logic freq_select_hi_bit,
    input wire logic freq_select_lo_bit,
    input wire logic boost_enable_switch,
    input wire logic ch1_pulse_select,
    input wire logic [1:0] direction_logic_jumper,
    input wire logic reset_switch,
    input wire logic pf_option_fitted,
    input wire logic [1:0] loop_fault,
    // outputs
    input wire logic tune_req,
    input wire logic osc_mux_sel,
    input wire logic [1:0] osc_freq_sel,
    input wire logic [1:0][1:0] sens_level,
    input wire logic [1:0] pf_store_det,
    input wire logic [1:0] relay_close,
    input wire logic [1:0] chan_led
);
    // ********
    // helper state
    // ********
    logic [1:0] age_r;
    logic mux_prev_r, seen_r, boost_r, pres_r;
    logic [31:0] gap_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_r <= 2'h0;
            mux_prev_r <= 1'b0;
            seen_r <= 1'b0;
            boost_r <= 1'b0;
            pres_r <= 1'b1;
            gap_r <= 32'h0;
        end else begin
            if (age_r != 2'h3) age_r <= age_r + 2'h1;
            mux_prev_r <= osc_mux_sel;
            gap_r <= (osc_mux_sel != mux_prev_r) ? 32'h0 : gap_r + 32'h1;
            if (osc_mux_sel != mux_prev_r) seen_r <= 1'b1;
            // config as latched when tuning starts
            if (tune_req) begin
                boost_r <= boost_enable_switch;
                pres_r <= !ch1_pulse_select && ~^direction_logic_jumper;
            end
        end
    end
    // ********
    // properties
    // ********
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_one_shot;
        tune_req |=> !tune_req;
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("long tune pulse");
    property p_power_tune;
        age_r == 2'h1 && !pf_option_fitted |-> tune_req;
    endproperty
    a_power_tune: assert property (p_power_tune) else $error("no power tune");
    property p_press;
        $rose(reset_switch) && age_r == 2'h3 |-> ##[1:2] tune_req;
    endproperty
    a_press: assert property (p_press) else $error("no retune");
    property p_freq;
        tune_req |-> ##[0:2] osc_freq_sel == {freq_select_hi_bit, freq_select_lo_bit};
    endproperty
    a_freq: assert property (p_freq) else $error("freq code");
    property p_mux;
        seen_r && osc_mux_sel != mux_prev_r |-> gap_r == MS_CYC - 1;
    endproperty
    a_mux: assert property (p_mux) else $error("mux period");
    property p_boost;
        $rose(pf_store_det[0]) && boost_r |-> ##[0:2] sens_level[0] == 2'h0;
    endproperty
    a_boost: assert property (p_boost) else $error("no boost");
    property p_presence;
        $rose(pf_store_det[0]) && pres_r |-> ##[1:3] relay_close[0];
    endproperty
    a_presence: assert property (p_presence) else $error("relay late");
    property p_led;
        $rose(pf_store_det[0]) && !loop_fault[0] |-> ##[0:2] chan_led[0];
    endproperty
    a_led: assert property (p_led) else $error("detect led late");
endmodule // loop_det_checker
bind loop_detector_config_output_ctrl loop_det_checker #(.MS_CYC(MS_CYC)) u_chk (
    .pclk, .presetn, .freq_select_hi_bit, .freq_select_lo_bit, .boost_enable_switch,
    .ch1_pulse_select, .direction_logic_jumper, .reset_switch, .pf_option_fitted, .loop_fault,
    .tune_req, .osc_mux_sel, .osc_freq_sel, .sens_level, .pf_store_det, .relay_close, .chan_led);

//--- tb/loop_front_model.sv
// front end stand-in: tunes on request and reports the bench's vehicles
`timescale 1ns/100ps
module loop_front_model #(
    parameter int unsigned TUNE_CYC = 40
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // tuning handshake
    input wire logic tune_req,
    output logic tune_done,
    // loop state
    input wire logic [1:0] veh,
    input wire logic [1:0] flt,
    output logic [1:0] loop_detect,
    output logic [1:0] loop_fault
);
    logic [7:0] cnt_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 8'h0;
            tune_done <= 1'b0;
            loop_detect <= 2'h0;
            loop_fault <= 2'h0;
        end else begin
            // a broken loop senses nothing
            loop_detect <= veh & ~flt;
            loop_fault <= flt;
            tune_done <= !tune_req && cnt_r == 8'h1;
            if (tune_req) begin
                cnt_r <= 8'(TUNE_CYC);
            end else if (cnt_r != 8'h0) begin
                cnt_r <= cnt_r - 8'h1;
            end
        end
    end
endmodule // loop_front_model

//--- tb/loop_detector_config_output_ctrl_tb.sv
// self-checking bench for the loop detector control block
`timescale 1ns/100ps
module loop_detector_config_output_ctrl_tb;
    import loop_det_pkg::*;
    localparam int unsigned MS = 10;
    localparam int unsigned LIM = 2;
    int miscompares = 0;
    int n_compared = 0;
    int n, t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic freq_select_hi_bit, freq_select_lo_bit, ch1_sens_a, ch1_sens_b, ch2_sens_a, ch2_sens_b;
    logic boost_enable_switch, presence_time_switch, ch1_pulse_select, ch2_pulse_select;
    logic reset_switch, tune_done, tune_req, osc_mux_sel, power_led;
    logic pf_option_fitted, pf_outage_short;
    logic [1:0] direction_logic_jumper, loop_detect, loop_fault, osc_freq_sel, drift_track;
    logic [1:0] veh, flt, pf_saved_det, pf_store_det, relay_close, chan_led;
    logic [1:0][3:0] delta_mag;
    logic [1:0][1:0] sens_level;
    loop_detector_config_output_ctrl #(.MS_CYC(MS), .LIM_UNIT(LIM)) DUT (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .freq_select_hi_bit, .freq_select_lo_bit, .ch1_sens_a, .ch1_sens_b, .ch2_sens_a,
        .ch2_sens_b, .boost_enable_switch, .presence_time_switch, .ch1_pulse_select,
        .ch2_pulse_select, .direction_logic_jumper, .reset_switch, .loop_detect, .loop_fault,
        .delta_mag, .tune_done, .tune_req, .osc_mux_sel, .osc_freq_sel, .sens_level,
        .drift_track, .pf_option_fitted, .pf_outage_short, .pf_saved_det, .pf_store_det,
        .relay_close, .chan_led, .power_led);
    loop_front_model FE (.pclk, .presetn, .tune_req, .tune_done, .veh, .flt, .loop_detect,
        .loop_fault);
    // ********
    // shared tasks
    // ********
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic press(input logic by_bus);
        if (by_bus) apb(1'b1, CTRL_OFF, 32'h1);
        else begin
            reset_switch <= 1'b1;
            cyc(2);
            reset_switch <= 1'b0;
        end
        cyc(6);
    endtask
    task automatic settle();
        int k;
        k = 0;
        while (tune_done !== 1'b1 && k < 500) begin
            @(posedge pclk);
            k++;
        end
        cyc(3);
        chk("led_tuned", 0, chan_led);
    endtask
    task automatic len(ref logic [1:0] s, input int b, output int m);
        int k;
        k = 0;
        m = 0;
        while (s[b] !== 1'b1 && k < 100) begin
            @(posedge pclk);
            k++;
        end
        while (s[b] === 1'b1 && m < 3000) begin
            @(posedge pclk);
            m++;
        end
    endtask
    task automatic flashes(output int m);
        logic p;
        m = 0;
        p = chan_led[0];
        repeat (3000) begin
            @(posedge pclk);
            if (chan_led[0] !== p) m++;
            p = chan_led[0];
        end
    endtask
    // ********
    // scenarios
    // ********
    task automatic t_power();
        cyc(6);
        chk("led_tuning", 2'h3, chan_led);
        chk("power_led", 1, power_led);
        settle();
        chk("freq_default", 0, osc_freq_sel);
        apb(1'b0, CONFIG_OFF, 32'h0);
        chk("config_default", 0, rd);
        apb(1'b0, 12'hffc, 32'h0);
        chk("unmapped_err", 1, err);
    endtask
    task automatic t_config();
        for (int i = 0; i < 4; i++) begin
            {freq_select_hi_bit, freq_select_lo_bit} <= 2'(i);
            {ch1_sens_b, ch1_sens_a} <= 2'(i);
            {ch2_sens_b, ch2_sens_a} <= 2'(3 - i);
            cyc(1);
            press(i[0]);
            chk("led_tuning", 2'h3, chan_led);
            settle();
            chk("freq_code", i, osc_freq_sel);
            chk("sens_codes", {2'(3 - i), 2'(i)}, sens_level);
            apb(1'b0, CONFIG_OFF, 32'h0);
            chk("config_word", {2'(i), 2'(3 - i), 2'(i)}, rd[12:7]);
        end
    endtask
    task automatic t_boost();
        boost_enable_switch <= 1'b1;
        presence_time_switch <= 1'b1;
        press(1'b0);
        settle();
        veh <= 2'h1;
        cyc(8);
        chk("sens_boosted", 0, sens_level[0]);
        chk("drift_on", 2'h1, drift_track);
        chk("led_det", 2'h1, chan_led);
        cyc(200);
        chk("relay_held", 2'h1, relay_close);
        veh <= 2'h0;
        cyc(8);
        chk("sens_back", 3, sens_level[0]);
        chk("relay_open", 0, relay_close);
    endtask
    task automatic t_pulse();
        boost_enable_switch <= 1'b0;
        ch2_pulse_select <= 1'b1;
        press(1'b0);
        settle();
        veh <= 2'h3;
        len(relay_close, 1, n);
        chk("pulse_len", 1, n >= 150 * MS && n <= 151 * MS);
        chk("sens_unboosted", 3, sens_level[0]);
        veh <= 2'h0;
        ch2_pulse_select <= 1'b0;
        cyc(8);
    endtask
    task automatic t_dir();
        direction_logic_jumper <= 2'h1;
        press(1'b0);
        chk("alt_flash", 1, chan_led[0] !== chan_led[1]);
        settle();
        veh <= 2'h1;
        cyc(10);
        chk("dir_first", 0, relay_close);
        veh <= 2'h3;
        cyc(10);
        chk("dir_closed", 2'h1, relay_close);
        veh <= 2'h2;
        cyc(10);
        chk("dir_held", 2'h1, relay_close);
        veh <= 2'h0;
        cyc(10);
        chk("dir_open", 0, relay_close);
        direction_logic_jumper <= 2'h2;
        press(1'b0);
        settle();
        veh <= 2'h1;
        cyc(10);
        veh <= 2'h2;
        len(relay_close, 0, n);
        chk("dir_pulse", 1, n >= 150 * MS && n <= 151 * MS);
        veh <= 2'h0;
        direction_logic_jumper <= 2'h0;
    endtask
    task automatic t_limit();
        presence_time_switch <= 1'b0;
        delta_mag <= 8'h01;
        press(1'b0);
        settle();
        veh <= 2'h1;
        len(pf_store_det, 0, n);
        chk("limit_len", 1, n >= (2 * LIM - 1) * MS && n <= 2 * LIM * MS + 2);
        veh <= 2'h0;
        cyc(8);
    endtask
    task automatic t_fault();
        flt <= 2'h1;
        flashes(t);
        chk("fault_flash", 1, t >= 2);
        chk("fault_relay", 2'h1, relay_close);
        flt <= 2'h0;
        flashes(t);
        chk("fault_latched", 1, t >= 2);
        press(1'b0);
        settle();
    endtask
    task automatic t_pfail();
        presetn <= 1'b0;
        pf_option_fitted <= 1'b1;
        pf_outage_short <= 1'b1;
        pf_saved_det <= 2'h1;
        cyc(3);
        presetn <= 1'b1;
        t = 0;
        repeat (20) begin
            @(posedge pclk);
            t += int'(tune_req === 1'b1);
        end
        chk("no_retune", 0, t);
        chk("restored_det", 2'h1, pf_store_det);
        chk("restored_relay", 2'h1, relay_close);
        pf_option_fitted <= 1'b0;
        cyc(PF_SETTLE_MS * MS + 20);
        chk("live_det", 0, pf_store_det);
    endtask
    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ********
    // run
    // ********
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        #400000;
        miscompares++;
        summarize();
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, reset_switch, pf_option_fitted, pf_outage_short} = '0;
        {freq_select_hi_bit, freq_select_lo_bit, ch1_sens_a, ch1_sens_b} = '0;
        {ch2_sens_a, ch2_sens_b, boost_enable_switch, presence_time_switch} = '0;
        {ch1_pulse_select, ch2_pulse_select, direction_logic_jumper} = '0;
        {paddr, pwdata, veh, flt, pf_saved_det, delta_mag} = '0;
        cyc(6);
        presetn <= 1'b1;
        t_power();
        t_config();
        t_boost();
        t_pulse();
        t_dir();
        t_limit();
        t_fault();
        t_pfail();
        summarize();
    end
endmodule // loop_detector_config_output_ctrl_tb
